// file: core/gpde_reg.v
// masked software register with synchronous reset
`timescale 1ns/1ns
`default_nettype none
module gpde_reg #(
  parameter WIDTH = 7,
  parameter [WIDTH-1:0] MASK = {WIDTH{1'b1}},
  parameter [WIDTH-1:0] RST = {WIDTH{1'b0}}
) (
  input wire clk_i,
  input wire reset_i,
  input wire ce_i,
  input wire we_i,
  input wire [WIDTH-1:0] wdata_i,
  output wire [WIDTH-1:0] q_o
);
  reg [WIDTH-1:0] q_ff;
  // unimplemented bits never store, so they read zero
  always @(posedge clk_i) begin
    if (reset_i) begin
      q_ff <= RST;
    end else if (ce_i && we_i) begin
      q_ff <= wdata_i & MASK;
    end
  end
  assign q_o = q_ff;
endmodule // gpde_reg
`default_nettype wire

// file: core/gpde_sync.v
// two-flop synchroniser for a bus of pin levels
`timescale 1ns/1ns
`default_nettype none
module gpde_sync #(
  parameter WIDTH = 8
) (
  input wire clk_i,
  input wire reset_i,
  input wire ce_i,
  input wire [WIDTH-1:0] async_i,
  output wire [WIDTH-1:0] sync_o
);
  reg [WIDTH-1:0] meta_ff;
  reg [WIDTH-1:0] sync_ff;
  // first stage is read only by the second
  always @(posedge clk_i) begin
    if (reset_i) begin
      meta_ff <= {WIDTH{1'b0}};
      sync_ff <= {WIDTH{1'b0}};
    end else if (ce_i) begin
      meta_ff <= async_i;
      sync_ff <= meta_ff;
    end
  end
  assign sync_o = sync_ff;
endmodule // gpde_sync
`default_nettype wire

// file: core/gpde_top.v
// gpio control for an 8-pin input-only port and a 7-pin bidirectional port
// Summary of operation
// [RULE_01] input port function register: bits 3..0 route pins to timer capture
// [RULE_02] input port pull-up register: eight bits, 1 enables pull-up, reset zero
// [RULE_03] input port input-enable register: eight bits, 1 enables input, reset zero
// [RULE_04] seven bidirectional pins, direction chosen per bit
// [RULE_05] io pins can carry serial channel and remote-control signals
// [RULE_06] after reset io pins are gpio with input, driver, pull-up off
// [RULE_07] two select registers; both zero means gpio, one set picks alternate
// [RULE_08] software must never set both select bits of one pin
// [RULE_09] io registers decode at offsets 00,04,08,0c,28,2c,38
// [RULE_10] io data register: bits 6..0, upper bits read zero, reset zero
// [RULE_11] io output-enable register: 1 enables driver, reset zero
// [RULE_12] first select register: one bit per pin, reset zero
// [RULE_13] first select maps pins to serial0, remote input, serial1 signals
// [RULE_14] second select holds only bits 6 and 2 for clear-to-send inputs
// [RULE_15] open-drain register: 1 gives open-drain drive, reset zero
// [RULE_16] io pull-up and input-enable registers: bits 6..0, reset zero
// [RULE_17] gpio output drives data bit; data reads pin only where input enabled
//
// Chosen here: strobed register access.
`timescale 1ns/1ns
`default_nettype none
`include "gpde_regs.vh"
module gpde_top #(
  parameter D_PINS = 8,
  parameter E_PINS = 7
) (
  input wire clk_i,
  input wire reset_i,
  input wire ce_i,
  input wire [7:0] addr_i,
  input wire [31:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  output reg [31:0] rdata_o,
  // input-only port pins and controls
  input wire [D_PINS-1:0] inport_pin_i,
  output reg [D_PINS-1:0] inport_pullup_o,
  output reg timer_a_capture_in0_o,
  output reg timer_a_capture_in1_o,
  output reg timer_b_capture_in0_o,
  output reg timer_b_capture_in1_o,
  // bidirectional port pins
  input wire [E_PINS-1:0] ioport_pin_i,
  output reg [E_PINS-1:0] ioport_pin_o,
  output reg [E_PINS-1:0] ioport_pin_oe_o,
  output reg [E_PINS-1:0] ioport_pullup_o,
  // serial and remote-control peripheral side
  input wire serial0_transmit_i,
  input wire serial0_clock_out_i,
  input wire serial0_clock_oe_i,
  input wire serial1_transmit_i,
  input wire serial1_clock_out_i,
  input wire serial1_clock_oe_i,
  output reg serial0_receive_o,
  output reg serial0_clock_o,
  output reg serial0_clear_to_send_o,
  output reg serial1_receive_o,
  output reg serial1_clock_o,
  output reg serial1_clear_to_send_o,
  output reg remote_control_input_o
);
  wire [6:0] e_data;
  wire [6:0] e_oe;
  wire [6:0] e_alt1;
  wire [6:0] e_alt2;
  wire [6:0] e_od;
  wire [6:0] e_pup;
  wire [6:0] e_ie;
  wire [3:0] d_alt;
  wire [7:0] d_pup;
  wire [7:0] d_ie;
  wire [7:0] d_sync;
  wire [6:0] e_sync;
  reg [31:0] nxt_rdata;
  reg [6:0] nxt_drv;
  reg [6:0] nxt_oe;
  integer i;

  // address match for one register write
  function wr_hit;
    input [7:0] a;
    input [7:0] ofs;
    input w;
    begin
      wr_hit = w && (a == ofs);
    end
  endfunction

  // each register clears its own unimplemented bits, so the read mux needs no mask
  // [RULE_09] io register decode
  // [RULE_10] io data register
  gpde_reg #(.WIDTH(7), .MASK(`GPDE_E_MASK), .RST(`GPDE_E_RST)) u_e_data (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .ce_i(ce_i),
    .we_i(wr_hit(addr_i, `GPDE_E_DATA_OFS, wr_i)),
    .wdata_i(wdata_i[6:0]),
    .q_o(e_data)
  );
  // [RULE_11] output enable register
  gpde_reg #(.WIDTH(7), .MASK(`GPDE_E_MASK), .RST(`GPDE_E_RST)) u_e_oe (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .ce_i(ce_i),
    .we_i(wr_hit(addr_i, `GPDE_E_OE_OFS, wr_i)),
    .wdata_i(wdata_i[6:0]),
    .q_o(e_oe)
  );
  // [RULE_12] first select register
  gpde_reg #(.WIDTH(7), .MASK(`GPDE_E_MASK), .RST(`GPDE_E_RST)) u_e_alt1 (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .ce_i(ce_i),
    .we_i(wr_hit(addr_i, `GPDE_E_ALT1_OFS, wr_i)),
    .wdata_i(wdata_i[6:0]),
    .q_o(e_alt1)
  );
  // [RULE_14] only bits 6 and 2 stored
  gpde_reg #(.WIDTH(7), .MASK(`GPDE_E_ALT2_MASK), .RST(`GPDE_E_RST)) u_e_alt2 (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .ce_i(ce_i),
    .we_i(wr_hit(addr_i, `GPDE_E_ALT2_OFS, wr_i)),
    .wdata_i(wdata_i[6:0]),
    .q_o(e_alt2)
  );
  // [RULE_15] open-drain register
  gpde_reg #(.WIDTH(7), .MASK(`GPDE_E_MASK), .RST(`GPDE_E_RST)) u_e_od (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .ce_i(ce_i),
    .we_i(wr_hit(addr_i, `GPDE_E_OD_OFS, wr_i)),
    .wdata_i(wdata_i[6:0]),
    .q_o(e_od)
  );
  // [RULE_16] pull-up and input enable registers
  gpde_reg #(.WIDTH(7), .MASK(`GPDE_E_MASK), .RST(`GPDE_E_RST)) u_e_pup (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .ce_i(ce_i),
    .we_i(wr_hit(addr_i, `GPDE_E_PUP_OFS, wr_i)),
    .wdata_i(wdata_i[6:0]),
    .q_o(e_pup)
  );
  gpde_reg #(.WIDTH(7), .MASK(`GPDE_E_MASK), .RST(`GPDE_E_RST)) u_e_ie (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .ce_i(ce_i),
    .we_i(wr_hit(addr_i, `GPDE_E_IE_OFS, wr_i)),
    .wdata_i(wdata_i[6:0]),
    .q_o(e_ie)
  );
  // [RULE_01] input port function register
  gpde_reg #(.WIDTH(4), .MASK(`GPDE_D_ALT_MASK), .RST(`GPDE_D_ALT_RST)) u_d_alt (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .ce_i(ce_i),
    .we_i(wr_hit(addr_i, `GPDE_D_ALT_OFS, wr_i)),
    .wdata_i(wdata_i[3:0]),
    .q_o(d_alt)
  );
  // [RULE_02] input port pull-up register
  gpde_reg #(.WIDTH(8), .MASK(`GPDE_D_MASK), .RST(`GPDE_D_RST)) u_d_pup (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .ce_i(ce_i),
    .we_i(wr_hit(addr_i, `GPDE_D_PUP_OFS, wr_i)),
    .wdata_i(wdata_i[7:0]),
    .q_o(d_pup)
  );
  // [RULE_03] input port input enable register
  gpde_reg #(.WIDTH(8), .MASK(`GPDE_D_MASK), .RST(`GPDE_D_RST)) u_d_ie (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .ce_i(ce_i),
    .we_i(wr_hit(addr_i, `GPDE_D_IE_OFS, wr_i)),
    .wdata_i(wdata_i[7:0]),
    .q_o(d_ie)
  );

  // pins come from outside the clock domain
  // two flops cost two cycles of pin latency but bound metastability
  gpde_sync #(.WIDTH(8)) u_d_sync (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .ce_i(ce_i),
    .async_i(inport_pin_i[7:0]),
    .sync_o(d_sync)
  );
  gpde_sync #(.WIDTH(7)) u_e_sync (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .ce_i(ce_i),
    .async_i(ioport_pin_i[6:0]),
    .sync_o(e_sync)
  );

  // read mux; unmapped offsets read zero
  always @* begin
    nxt_rdata = 32'h0000_0000;
    case (addr_i)
      // [RULE_17] data reads gated pin level
      `GPDE_E_DATA_OFS: nxt_rdata = {25'h0, e_sync & e_ie};
      `GPDE_E_OE_OFS: nxt_rdata = {25'h0, e_oe};
      `GPDE_E_ALT1_OFS: nxt_rdata = {25'h0, e_alt1};
      `GPDE_E_ALT2_OFS: nxt_rdata = {25'h0, e_alt2};
      `GPDE_E_OD_OFS: nxt_rdata = {25'h0, e_od};
      `GPDE_E_PUP_OFS: nxt_rdata = {25'h0, e_pup};
      `GPDE_E_IE_OFS: nxt_rdata = {25'h0, e_ie};
      `GPDE_D_DATA_OFS: nxt_rdata = {24'h000000, d_sync & d_ie};
      `GPDE_D_ALT_OFS: nxt_rdata = {28'h0000000, d_alt};
      `GPDE_D_PUP_OFS: nxt_rdata = {24'h000000, d_pup};
      `GPDE_D_IE_OFS: nxt_rdata = {24'h000000, d_ie};
      default: nxt_rdata = 32'h0000_0000;
    endcase
  end

  // pin drive: gpio uses data and oe; alternates take peripheral outputs
  always @* begin
    nxt_drv = e_data;
    nxt_oe = e_oe;
    // [RULE_13] transmit and clock outputs under first select
    if (e_alt1[0]) begin
      nxt_drv[0] = serial0_transmit_i;
      nxt_oe[0] = 1'b1;
    end
    if (e_alt1[2]) begin
      nxt_drv[2] = serial0_clock_out_i;
      nxt_oe[2] = serial0_clock_oe_i;
    end
    if (e_alt1[4]) begin
      nxt_drv[4] = serial1_transmit_i;
      nxt_oe[4] = 1'b1;
    end
    if (e_alt1[6]) begin
      nxt_drv[6] = serial1_clock_out_i;
      nxt_oe[6] = serial1_clock_oe_i;
    end
    // receive, remote and clear-to-send pins are inputs only
    if (e_alt1[1]) nxt_oe[1] = 1'b0;
    if (e_alt1[3]) nxt_oe[3] = 1'b0;
    if (e_alt1[5]) nxt_oe[5] = 1'b0;
    // a pin set in both selects is forbidden; leaving it undriven is the safe side
    // [RULE_14] clear-to-send selection never drives
    if (e_alt2[2]) nxt_oe[2] = 1'b0;
    if (e_alt2[6]) nxt_oe[6] = 1'b0;
    // applied last so that alternate outputs honour open-drain as well
    // [RULE_15] open-drain drives only a low level
    for (i = 0; i < 7; i = i + 1) begin
      if (e_od[i]) begin
        nxt_oe[i] = nxt_oe[i] & ~nxt_drv[i];
        nxt_drv[i] = 1'b0;
      end
    end
  end

  // registered outputs; reset leaves every pin undriven and pulls off
  // a low clock enable holds every output as it stands
  always @(posedge clk_i) begin
    if (reset_i) begin
      rdata_o <= 32'h0000_0000;
      inport_pullup_o <= {D_PINS{1'b0}};
      timer_a_capture_in0_o <= 1'b0;
      timer_a_capture_in1_o <= 1'b0;
      timer_b_capture_in0_o <= 1'b0;
      timer_b_capture_in1_o <= 1'b0;
      // [RULE_06] pins start as disabled gpio
      ioport_pin_o <= {E_PINS{1'b0}};
      ioport_pin_oe_o <= {E_PINS{1'b0}};
      ioport_pullup_o <= {E_PINS{1'b0}};
      serial0_receive_o <= 1'b0;
      serial0_clock_o <= 1'b0;
      serial0_clear_to_send_o <= 1'b0;
      serial1_receive_o <= 1'b0;
      serial1_clock_o <= 1'b0;
      serial1_clear_to_send_o <= 1'b0;
      remote_control_input_o <= 1'b0;
    end else if (ce_i) begin
      // read data valid only the cycle after the strobe
      rdata_o <= rd_i ? nxt_rdata : 32'h0000_0000;
      // [RULE_02] pull-up drive
      inport_pullup_o <= d_pup;
      // capture inputs see only the synchronised pin, never the raw one
      // [RULE_01] capture inputs gated by select and input enable
      timer_a_capture_in0_o <= d_alt[0] & d_ie[0] & d_sync[0];
      timer_a_capture_in1_o <= d_alt[1] & d_ie[1] & d_sync[1];
      timer_b_capture_in0_o <= d_alt[2] & d_ie[2] & d_sync[2];
      timer_b_capture_in1_o <= d_alt[3] & d_ie[3] & d_sync[3];
      // [RULE_04] per-bit direction
      ioport_pin_o <= nxt_drv;
      ioport_pin_oe_o <= nxt_oe;
      ioport_pullup_o <= e_pup;
      // [RULE_05] alternate inputs need select and input enable
      serial0_receive_o <= e_alt1[1] & e_ie[1] & e_sync[1];
      serial0_clock_o <= e_alt1[2] & e_ie[2] & e_sync[2];
      serial1_receive_o <= e_alt1[5] & e_ie[5] & e_sync[5];
      serial1_clock_o <= e_alt1[6] & e_ie[6] & e_sync[6];
      remote_control_input_o <= e_alt1[3] & e_ie[3] & e_sync[3];
      // [RULE_07] second select routes clear-to-send
      serial0_clear_to_send_o <= e_alt2[2] & e_ie[2] & e_sync[2];
      serial1_clear_to_send_o <= e_alt2[6] & e_ie[6] & e_sync[6];
    end
  end
endmodule // gpde_top
`default_nettype wire

// file: dv/gpde_monitor.sv
// concurrent checks on the port d/e gpio block, bound to its top
`timescale 1ns/1ns
`default_nettype none
module gpde_monitor #(
  parameter E_PINS = 7
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic ce_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [31:0] rdata_o,
  input wire logic [E_PINS-1:0] ioport_pin_o,
  input wire logic [E_PINS-1:0] ioport_pin_oe_o,
  input wire logic [E_PINS-1:0] ioport_pullup_o,
  input wire logic serial0_transmit_i
);
  logic [E_PINS-1:0] dat_ff, oe_ff, a1_ff, a2_ff, od_ff, pup_ff, pp, odm;
  // shadow of written controls; a write with the clock enable low is dropped
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      {dat_ff, oe_ff, a1_ff, a2_ff, od_ff, pup_ff} <= '0;
    end else if (wr_i && ce_i) begin
      case (addr_i)
        8'h00: dat_ff <= wdata_i[E_PINS-1:0];
        8'h04: oe_ff <= wdata_i[E_PINS-1:0];
        8'h08: a1_ff <= wdata_i[E_PINS-1:0];
        8'h0c: a2_ff <= wdata_i[E_PINS-1:0] & 7'h44;
        8'h28: od_ff <= wdata_i[E_PINS-1:0];
        8'h2c: pup_ff <= wdata_i[E_PINS-1:0];
        default: ;
      endcase
    end
  end
  // general-purpose pins split into push-pull and open-drain
  assign pp = ~(a1_ff | a2_ff | od_ff);
  assign odm = ~(a1_ff | a2_ff) & od_ff;
  default clocking dcb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  property p_rd_idle; !$past(rd_i) |-> rdata_o == 32'h0; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not zero");
  property p_rd_hole; rd_i && addr_i == 8'h10 |=> rdata_o == 32'h0; endproperty
  a_rd_hole: assert property (p_rd_hole) else $error("hole read not zero");
  property p_rd_upper; $past(rd_i) |-> rdata_o[31:8] == 24'h0; endproperty
  a_rd_upper: assert property (p_rd_upper) else $error("upper bits set");
  property p_rst_off; $fell(reset_i) |-> ioport_pin_oe_o == 0 && ioport_pullup_o == 0; endproperty
  a_rst_off: assert property (p_rst_off) else $error("pins active after reset");
  property p_pp_oe; (ioport_pin_oe_o & $past(pp)) == $past(oe_ff & pp); endproperty
  a_pp_oe: assert property (p_pp_oe) else $error("driver enable wrong");
  property p_pp_out; (ioport_pin_o & $past(pp & oe_ff)) == $past(dat_ff & pp & oe_ff); endproperty
  a_pp_out: assert property (p_pp_out) else $error("driven level wrong");
  property p_od_oe; (ioport_pin_oe_o & $past(odm)) == $past(oe_ff & ~dat_ff & odm); endproperty
  a_od_oe: assert property (p_od_oe) else $error("open-drain enable wrong");
  property p_pullup; ioport_pullup_o == $past(pup_ff); endproperty
  a_pullup: assert property (p_pullup) else $error("pull-up wrong");
  property p_tx; $past(a1_ff[0] & ~od_ff[0]) |->
    ioport_pin_oe_o[0] && ioport_pin_o[0] == $past(serial0_transmit_i); endproperty
  a_tx: assert property (p_tx) else $error("transmit route wrong");
endmodule  // gpde_monitor
bind gpde_top gpde_monitor #(.E_PINS(E_PINS)) i_mon (.clk_i(clk_i), .reset_i(reset_i),
  .ce_i(ce_i),
  .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
  .ioport_pin_o(ioport_pin_o), .ioport_pin_oe_o(ioport_pin_oe_o),
  .ioport_pullup_o(ioport_pullup_o), .serial0_transmit_i(serial0_transmit_i));
`default_nettype wire

// file: dv/gpde_pin_model.sv
// pin-side model: resolves the seven io pins from driver, pull-up and far side
`timescale 1ns/1ns
`default_nettype none
module gpde_pin_model (
  input wire logic [6:0] out_i,
  input wire logic [6:0] oe_i,
  input wire logic [6:0] pup_i,
  input wire logic [6:0] ext_i,
  output logic [6:0] pin_o
);
  // a driven pin shows its driver, a released one the pull-up or the far side
  assign pin_o = (oe_i & out_i) | (~oe_i & (pup_i | ext_i));
endmodule  // gpde_pin_model
`default_nettype wire

// file: dv/gpio_ports_d_e_control_bench.sv
// self-checking bench for the port d/e gpio block
`timescale 1ns/1ns
`default_nettype none
`define CMP(nm, e, s) begin \
  checks++; \
  if ((s) !== (e)) begin \
    n_mismatch++; \
    $display("CHECK FAILED %s exp %h got %h", nm, (e), (s)); \
  end \
end
module gpio_ports_d_e_control_bench;
  logic clk_i = 0, reset_i = 1, ce_i = 1, wr_i = 0, rd_i = 0;
  logic [7:0] addr_i = 0, ext_d = 0, d_pup;
  logic [31:0] wdata_i = 0, rdata_o, d;
  logic [6:0] ext_e = 0, ioport_pin_i, ioport_pin_o, ioport_pin_oe_o, ioport_pullup_o, alt_o, e;
  logic [3:0] per = 0, per_q = 0, tmr_o;
  logic [1:0] cts_o;
  integer seed = 32'hbf5b2479;
  int checks = 0, n_mismatch = 0, cyc = 0;
  logic [31:0] mdl [0:255] = '{default: 32'h0};
  logic [7:0] adr [12] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h28, 8'h2c, 8'h38, 8'h40,
    8'h48, 8'h6c, 8'h78, 8'h10};
  logic [7:0] gpr [7] = '{8'h00, 8'h04, 8'h28, 8'h2c, 8'h38, 8'h6c, 8'h78};
  initial forever #5 clk_i = ~clk_i;
  gpde_top i_dut (.clk_i, .reset_i, .ce_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
    .inport_pin_i(ext_d), .inport_pullup_o(d_pup), .timer_a_capture_in0_o(tmr_o[0]),
    .timer_a_capture_in1_o(tmr_o[1]), .timer_b_capture_in0_o(tmr_o[2]),
    .timer_b_capture_in1_o(tmr_o[3]), .ioport_pin_i, .ioport_pin_o, .ioport_pin_oe_o,
    .ioport_pullup_o, .serial0_transmit_i(per[0]), .serial0_clock_out_i(per[1]),
    .serial0_clock_oe_i(1'b0), .serial1_transmit_i(per[2]), .serial1_clock_out_i(per[3]),
    .serial1_clock_oe_i(1'b0), .serial0_receive_o(alt_o[1]), .serial0_clock_o(alt_o[2]),
    .serial0_clear_to_send_o(cts_o[0]), .serial1_receive_o(alt_o[5]),
    .serial1_clock_o(alt_o[6]), .serial1_clear_to_send_o(cts_o[1]),
    .remote_control_input_o(alt_o[3]));
  gpde_pin_model i_pins (.out_i(ioport_pin_o), .oe_i(ioport_pin_oe_o),
    .pup_i(ioport_pullup_o), .ext_i(ext_e), .pin_o(ioport_pin_i));
  // implemented bits per address; unmapped and read-only places store nothing
  function automatic logic [31:0] msk(input logic [7:0] a);
    case (a)
      8'h00, 8'h04, 8'h08, 8'h28, 8'h2c, 8'h38: return 32'h7f;
      8'h0c: return 32'h44;
      8'h48: return 32'h0f;
      8'h6c, 8'h78: return 32'hff;
      default: return 32'h0;
    endcase
  endfunction
  // expected io pin level with every pin in general-purpose mode
  function automatic logic [6:0] io_lvl();
    logic [6:0] drv;
    drv = mdl[8'h04][6:0] & ~(mdl[8'h28][6:0] & mdl[8'h00][6:0]);
    return (drv & mdl[8'h00][6:0]) | (~drv & (mdl[8'h2c][6:0] | ext_e));
  endfunction
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_i);
    wr_i <= 1;
    addr_i <= a;
    wdata_i <= v;
    @(posedge clk_i);
    wr_i <= 0;
    // a write taken while the clock enable is low must not land
    if (ce_i) mdl[a] = v & msk(a);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    @(posedge clk_i);
    rd_i <= 1;
    addr_i <= a;
    @(posedge clk_i);
    rd_i <= 0;
    @(negedge clk_i);
    `CMP("rdata", x, rdata_o)
  endtask
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // peripheral outputs toggle at random; a hang is cut short by the cycle ceiling
  always @(posedge clk_i) begin
    per <= $random(seed);
    // per_q holds the transmit levels that the design samples at this edge
    per_q <= per;
    cyc++;
    if (cyc == 5000) begin
      n_mismatch++;
      end_sim();
    end
  end
  initial begin
    repeat (2) @(posedge clk_i);
    reset_i <= 0;
    foreach (adr[i]) rd(adr[i], 32'h0);
    // a low clock enable drops a write and holds the pin drive
    @(posedge clk_i) ce_i <= 0;
    wr(8'h04, 32'h7f);
    ce_i <= 1;
    rd(8'h04, 32'h0);
    `CMP("frozen drive", 7'h00, ioport_pin_oe_o)
    // random contents everywhere, read back through the implemented bits except at 00 and 40
    repeat (3) foreach (adr[i]) begin
      d = $random(seed);
      // never select both alternates of one pin
      if (adr[i] == 8'h08) d &= ~mdl[8'h0c];
      if (adr[i] == 8'h0c) d &= ~mdl[8'h08];
      wr(adr[i], d);
      if (adr[i] != 8'h00 && adr[i] != 8'h40) rd(adr[i], mdl[adr[i]]);
    end
    wr(8'h0c, 32'h0);
    wr(8'h08, 32'h0);
    // general-purpose drive, open-drain and input paths with random settings
    repeat (8) begin
      @(posedge clk_i);
      ext_e <= $random(seed);
      ext_d <= $random(seed);
      foreach (gpr[i]) wr(gpr[i], $random(seed));
      repeat (4) @(posedge clk_i);
      rd(8'h00, io_lvl() & mdl[8'h38]);
      rd(8'h40, ext_d & mdl[8'h78]);
      `CMP("inport pull-up", mdl[8'h6c][7:0], d_pup)
    end
    wr(8'h28, 32'h0);
    // alternate routes: all of select one, then select one beside select two
    for (int k = 0; k < 2; k++) begin
      wr(8'h0c, 32'h0);
      wr(8'h08, k ? 32'h3b : 32'h7f);
      wr(8'h0c, k ? 32'h44 : 32'h0);
      wr(8'h48, $random(seed));
      repeat (4) @(posedge clk_i);
      // look between edges, never in the step that launches the outputs
      @(negedge clk_i);
      e = mdl[8'h38][6:0] & (mdl[8'h2c][6:0] | ext_e);
      `CMP("alternate in", mdl[8'h08][6:0] & e & 7'h6e, alt_o & 7'h6e)
      `CMP("clear to send", {e[6], e[2]} & {mdl[8'h0c][6], mdl[8'h0c][2]}, cts_o)
      `CMP("timer", ext_d[3:0] & mdl[8'h78][3:0] & mdl[8'h48][3:0], tmr_o)
      `CMP("alternate drive", 7'h11, ioport_pin_oe_o)
      `CMP("transmit", {per_q[2], per_q[0]}, {ioport_pin_o[4], ioport_pin_o[0]})
    end
    end_sim();
  end
endmodule  // gpio_ports_d_e_control_bench
`default_nettype wire

// file: pkg/gpde_regs.vh
// register offsets, field positions and reset values for the port d/e gpio block
`ifndef GPDE_REGS_VH
`define GPDE_REGS_VH
// seven-pin port register byte offsets
`define GPDE_E_DATA_OFS 8'h00
`define GPDE_E_OE_OFS 8'h04
`define GPDE_E_ALT1_OFS 8'h08
`define GPDE_E_ALT2_OFS 8'h0c
`define GPDE_E_OD_OFS 8'h28
`define GPDE_E_PUP_OFS 8'h2c
`define GPDE_E_IE_OFS 8'h38
// input-only port registers, placed in a block of their own above the port e set
`define GPDE_D_DATA_OFS 8'h40
`define GPDE_D_ALT_OFS 8'h48
`define GPDE_D_PUP_OFS 8'h6c
`define GPDE_D_IE_OFS 8'h78
// implemented-bit masks
`define GPDE_E_MASK 7'h7f
`define GPDE_E_ALT2_MASK 7'h44
`define GPDE_D_ALT_MASK 4'hf
`define GPDE_D_MASK 8'hff
// reset values
`define GPDE_E_RST 7'h00
`define GPDE_D_RST 8'h00
`define GPDE_D_ALT_RST 4'h0
`endif
